/* File: ftf_consts.svh */
// Offsets, byte values and timing counts of the track framer
`ifndef FTF_CONSTS_SVH
`define FTF_CONSTS_SVH

// Clock and bit cell timing
`define FTF_CLOCK_NS      20
`define FTF_CELL_NS       2000
`define FTF_HALF_CYCLES   (`FTF_CELL_NS / 2 / `FTF_CLOCK_NS)

// Track geometry
`define FTF_TRACKS        40
`define FTF_SECTORS       8
`define FTF_SECTOR_BYTES  512
`define FTF_HEADER_BYTES  92
`define FTF_SYNC_BYTES    12
`define FTF_MIN_SYNC      2
`define FTF_PRE_GAP       40
`define FTF_GAP1          36
`define FTF_GAP2          22
`define FTF_GAP3          54

// Field byte values
`define FTF_FILL_BYTE     8'h4E
`define FTF_SYNC_BYTE     8'h00
`define FTF_A1_BYTE       8'hA1
`define FTF_C2_BYTE       8'hC2
`define FTF_IAM_BYTE      8'hFC
`define FTF_IDAM_BYTE     8'hFE
`define FTF_DAM_BYTE      8'hFB
`define FTF_LEN_CODE      8'h02
`define FTF_MARK_COUNT    3

// Channel patterns of the marks with a missing clock
`define FTF_A1_PATTERN    16'h4489
`define FTF_C2_PATTERN    16'h5224
`define FTF_A1_CLK_DROP   16'h0020
`define FTF_C2_CLK_DROP   16'h0080

// CRC
`define FTF_CRC_POLY      16'h1021
`define FTF_CRC_PRESET    16'hFFFF
`endif

/* File: ftf_pkg.sv */
// Types shared by the track framer modules
package ftf_pkg;
   typedef enum logic [4:0] {
      W_IDLE, W_WAIT_INDEX, W_PRE, W_HSYNC, W_IMARK, W_IAM, W_GAP1,
      W_ISYNC, W_IDMARK, W_IDAM, W_ID, W_IDCRC, W_GAP2, W_DSYNC,
      W_DMARK, W_DAM, W_DATA, W_DCRC, W_GAP3, W_GAP4
   } write_state_t;

   typedef enum logic [2:0] {
      P_HUNT, P_MARK, P_CMARK, P_ID, P_DATA
   } read_state_t;
endpackage

/* File: byte_stream_if.sv */
// Valid/ready byte stream between the framer and its buffer
`timescale 1ns/100ps
interface byte_stream_if #(parameter int WIDTH = 8);
   logic             valid;
   logic             ready;
   logic [WIDTH-1:0] data;

   modport source (output valid, output data, input ready);
   modport sink   (input valid, input data, output ready);
endinterface

/* File: stream_buffer.sv */
// Small FIFO in the write data path
`timescale 1ns/100ps
module stream_buffer #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 2
) (
   // Clock and reset
   input  wire logic        i_clock,
   input  wire logic        i_arst_n,
   // Streams
   byte_stream_if.sink      up,
   byte_stream_if.source    down
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   generate
      if (DEPTH < 2) begin : g_bad_depth
         $error("stream_buffer needs DEPTH of at least 2");
      end
   endgenerate

   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW-1:0]    wr_ptr;
   logic [PW-1:0]    rd_ptr;
   logic [PW:0]      count;
   logic             not_full;
   logic             not_empty;
   wire              push = up.valid && not_full;
   wire              pop  = down.ready && not_empty;
   wire  [PW:0]      next_count = count + (PW+1)'(push) - (PW+1)'(pop);

   // Ready and valid come straight from flops
   assign up.ready   = not_full;
   assign down.valid = not_empty;
   assign down.data  = mem[rd_ptr];

   // Pointer wrap written out so DEPTH need not be a power of two
   function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
      bump = (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
   endfunction

   // Storage
   always_ff @(posedge i_clock) begin
      if (push) begin
         mem[wr_ptr] <= up.data;
      end
   end

   // Occupancy and flags
   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         wr_ptr    <= '0;
         rd_ptr    <= '0;
         count     <= '0;
         not_full  <= 1'b1;
         not_empty <= 1'b0;
      end else begin
         if (push) wr_ptr <= bump(wr_ptr);
         if (pop)  rd_ptr <= bump(rd_ptr);
         count     <= next_count;
         not_full  <= next_count != (PW+1)'(DEPTH);
         not_empty <= next_count != '0;
      end
   end
endmodule

/* File: floppy_track_format_framer.sv */
// Double density soft sector track formatter and field parser
//
// How it works
// - Tracks 0 to 39 only; higher track numbers are refused.
// - Eight soft sectors per track, each found by its recorded label.
// - Each sector carries exactly 512 data bytes.
// - After index, a 92 byte header ends with the first gap.
// - Header order: pre-index gap, sync, index mark, first gap.
// - Second gap between ID CRC and data sync.
// - Third gap after data; after sector 8 the fourth gap until index.
// - ID address: track, head, sector, length code, in that order.
// - Two CRC bytes follow the ID address.
// - Twelve sync bytes before the data address mark.
// - Two CRC bytes directly follow the user data.
// - Every sync run is at least two bytes long.
// - Index mark is a clock-violating byte, recognised by the parser.
// - ID mark is its own special byte, distinguishing ID fields.
// - Data mark differs from ID mark so data fields are told apart.
// - Search gives up with an error after one full revolution.
// - Drive is ready only after two index pulses.
// - Modified frequency coding with 2 us bit cells.
`timescale 1ns/100ps
`include "ftf_consts.svh"
module floppy_track_format_framer import ftf_pkg::*; #(
   parameter int TRACKS       = `FTF_TRACKS,
   parameter int SECTORS      = `FTF_SECTORS,
   parameter int SECTOR_BYTES = `FTF_SECTOR_BYTES,
   parameter int SYNC_BYTES   = `FTF_SYNC_BYTES,
   parameter int PRE_GAP      = `FTF_PRE_GAP,
   parameter int GAP1         = `FTF_GAP1,
   parameter int GAP2         = `FTF_GAP2,
   parameter int GAP3         = `FTF_GAP3,
   parameter int HALF_CYCLES  = `FTF_HALF_CYCLES
) (
   // Clock and reset
   input  wire logic       i_clock,
   input  wire logic       i_arst_n,
   // Drive
   input  wire logic       i_index,
   input  wire logic       i_rd_flux,
   output logic            o_flux,
   output logic            o_write_gate,
   output logic            o_drive_ready,
   // Commands
   input  wire logic       i_format_start,
   input  wire logic       i_search_start,
   input  wire logic [5:0] i_track,
   input  wire logic       i_head,
   input  wire logic [3:0] i_sector,
   output logic            o_busy,
   output logic            o_bad_track,
   output logic            o_found,
   output logic            o_search_error,
   output logic            o_crc_error,
   // Format data in
   input  wire logic [7:0] i_wr_data,
   input  wire logic       i_wr_valid,
   output logic            o_wr_ready,
   output logic            o_underrun,
   // Parsed fields out
   output logic            o_mark_index,
   output logic            o_mark_sector,
   output logic            o_mark_data,
   output logic [7:0]      o_rd_data,
   output logic            o_rd_valid
);
   localparam int HALF = HALF_CYCLES;

   generate
      if (PRE_GAP + SYNC_BYTES + `FTF_MARK_COUNT + 1 + GAP1 != `FTF_HEADER_BYTES) begin : g_hdr
         $error("track header must total 92 bytes");
      end
      if (SYNC_BYTES < `FTF_MIN_SYNC || SECTORS > 15 || TRACKS > 64 || SECTOR_BYTES > 1020
          || HALF_CYCLES < 2) begin : g_geo
         $error("framer geometry out of range");
      end
   endgenerate

   // Modified frequency coding of one byte, clock only between two zeros
   function automatic logic [15:0] mfm_encode(input logic [7:0] b, input logic prev);
      logic [15:0] w;
      logic        p;
      w = '0;
      p = prev;
      for (int i = 7; i >= 0; i--) begin
         w[2*i+1] = !p && !b[i];
         w[2*i]   = b[i];
         p        = b[i];
      end
      return w;
   endfunction

   // Data bits sit in the even channel positions
   function automatic logic [7:0] mfm_decode(input logic [15:0] w);
      logic [7:0] b;
      b = '0;
      for (int i = 0; i < 8; i++) begin
         b[i] = w[2*i];
      end
      return b;
   endfunction

   // CRC over one byte, most significant bit first
   function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
      logic [15:0] r;
      logic        fb;
      r = c;
      for (int i = 7; i >= 0; i--) begin
         fb = r[15] ^ b[i];
         r  = {r[14:0], 1'b0} ^ (fb ? `FTF_CRC_POLY : 16'h0000);
      end
      return r;
   endfunction

   // Half bit cell divider: one pulse every 1 us
   logic [$clog2(HALF)-1:0] div;
   logic                    half_tick;
   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         div       <= '0;
         half_tick <= 1'b0;
      end else begin
         half_tick <= div == $bits(div)'(HALF - 1);
         div       <= (div == $bits(div)'(HALF - 1)) ? '0 : div + 1'b1;
      end
   end

   // Index edge and drive ready after two pulses
   logic       index_d;
   logic [1:0] ready_cnt;
   wire        index_edge = i_index && !index_d;
   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         index_d       <= 1'b0;
         ready_cnt     <= '0;
         o_drive_ready <= 1'b0;
      end else begin
         index_d <= i_index;
         if (index_edge && ready_cnt != 2'd2) ready_cnt <= ready_cnt + 1'b1;
         o_drive_ready <= ready_cnt == 2'd2;
      end
   end

   // Format data buffer; the writer drains one byte per byte time
   byte_stream_if #(.WIDTH(8)) up ();
   byte_stream_if #(.WIDTH(8)) down ();
   assign up.valid   = i_wr_valid;
   assign up.data    = i_wr_data;
   assign o_wr_ready = up.ready;
   stream_buffer #(.WIDTH(8), .DEPTH(2)) u_buf (
      .i_clock  (i_clock),
      .i_arst_n (i_arst_n),
      .up       (up),
      .down     (down)
   );

   // Writer state
   write_state_t wstate;
   write_state_t seg_next;
   logic [15:0]  wcnt;
   logic [15:0]  seg_len;
   logic [3:0]   wbit;
   logic [15:0]  wshift;
   logic         wprev;
   logic [15:0]  wcrc;
   logic [3:0]   wsector;
   logic [5:0]   wtrack;
   logic         whead;
   logic [7:0]   wbyte;
   logic [15:0]  wdrop;
   wire          writing = wstate != W_IDLE && wstate != W_WAIT_INDEX;
   wire          wload   = writing && half_tick && wbit == 4'hF;
   wire          seg_end = wcnt == seg_len - 16'd1;
   wire          crc_in  = wstate inside {W_IDMARK, W_IDAM, W_ID, W_DMARK, W_DAM, W_DATA};
   wire          crc_pre = (wstate == W_IDMARK || wstate == W_DMARK) && wcnt == '0;
   wire [15:0]   next_wcrc = crc_byte(crc_pre ? `FTF_CRC_PRESET : wcrc, wbyte);
   wire          track_ok  = i_track < 6'(TRACKS);
   assign down.ready = wload && wstate == W_DATA;

   // Byte, length and successor of each track segment
   always_comb begin
      wbyte    = `FTF_FILL_BYTE;
      wdrop    = 16'h0000;
      seg_len  = 16'd1;
      seg_next = W_IDLE;
      case (wstate)
         W_PRE:    begin seg_len = 16'(PRE_GAP); seg_next = W_HSYNC; end
         W_HSYNC:  begin wbyte = `FTF_SYNC_BYTE; seg_len = 16'(SYNC_BYTES); seg_next = W_IMARK; end
         W_IMARK:  begin
            wbyte = `FTF_C2_BYTE; wdrop = `FTF_C2_CLK_DROP; seg_len = 16'(`FTF_MARK_COUNT); seg_next = W_IAM;
         end
         W_IAM:    begin wbyte = `FTF_IAM_BYTE; seg_next = W_GAP1; end
         W_GAP1:   begin seg_len = 16'(GAP1); seg_next = W_ISYNC; end
         W_ISYNC:  begin wbyte = `FTF_SYNC_BYTE; seg_len = 16'(SYNC_BYTES); seg_next = W_IDMARK; end
         W_IDMARK: begin
            wbyte = `FTF_A1_BYTE; wdrop = `FTF_A1_CLK_DROP; seg_len = 16'(`FTF_MARK_COUNT); seg_next = W_IDAM;
         end
         W_IDAM:   begin wbyte = `FTF_IDAM_BYTE; seg_next = W_ID; end
         W_ID:     begin
            seg_len  = 16'd4;
            seg_next = W_IDCRC;
            case (wcnt[1:0])
               2'd0:    wbyte = {2'b00, wtrack};
               2'd1:    wbyte = {7'h00, whead};
               2'd2:    wbyte = {4'h0, wsector};
               default: wbyte = `FTF_LEN_CODE;
            endcase
         end
         W_IDCRC:  begin wbyte = wcnt[0] ? wcrc[7:0] : wcrc[15:8]; seg_len = 16'd2; seg_next = W_GAP2; end
         W_GAP2:   begin seg_len = 16'(GAP2); seg_next = W_DSYNC; end
         W_DSYNC:  begin wbyte = `FTF_SYNC_BYTE; seg_len = 16'(SYNC_BYTES); seg_next = W_DMARK; end
         W_DMARK:  begin
            wbyte = `FTF_A1_BYTE; wdrop = `FTF_A1_CLK_DROP; seg_len = 16'(`FTF_MARK_COUNT); seg_next = W_DAM;
         end
         W_DAM:    begin wbyte = `FTF_DAM_BYTE; seg_next = W_DATA; end
         W_DATA:   begin
            wbyte = down.valid ? down.data : `FTF_SYNC_BYTE; seg_len = 16'(SECTOR_BYTES); seg_next = W_DCRC;
         end
         W_DCRC:   begin
            wbyte    = wcnt[0] ? wcrc[7:0] : wcrc[15:8];
            seg_len  = 16'd2;
            seg_next = (wsector == 4'(SECTORS)) ? W_GAP4 : W_GAP3;
         end
         W_GAP3:   begin seg_len = 16'(GAP3); seg_next = W_ISYNC; end
         W_GAP4:   begin seg_len = 16'hFFFF; seg_next = W_GAP4; end
         default:  begin seg_next = W_IDLE; end
      endcase
   end

   // Writer sequencing; the fourth gap runs until the next index
   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         wstate <= W_IDLE;
         wcnt   <= '0;
         wbit   <= '0;
         wtrack <= '0;
         whead  <= 1'b0;
      end else if (wstate == W_IDLE) begin
         if (i_format_start && track_ok && !o_busy) begin
            wstate <= W_WAIT_INDEX;
            wtrack <= i_track;
            whead  <= i_head;
         end
      end else if (wstate == W_WAIT_INDEX) begin
         if (index_edge) begin
            wstate <= W_PRE;
            wcnt   <= '0;
            wbit   <= 4'hF;
         end
      end else if (wstate == W_GAP4 && index_edge) begin
         wstate <= W_IDLE;
      end else if (half_tick) begin
         wbit <= wbit + 1'b1;
         if (wload && wstate != W_GAP4) begin
            wcnt   <= seg_end ? '0 : wcnt + 1'b1;
            wstate <= seg_end ? seg_next : wstate;
         end
      end
   end

   // Serialiser, CRC and sector count
   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         wshift       <= '0;
         wprev        <= 1'b0;
         wcrc         <= `FTF_CRC_PRESET;
         wsector      <= 4'h1;
         o_flux       <= 1'b0;
         o_write_gate <= 1'b0;
         o_underrun   <= 1'b0;
      end else begin
         o_write_gate <= writing && !(wstate == W_GAP4 && index_edge);
         o_underrun   <= down.ready && !down.valid;
         if (wstate == W_WAIT_INDEX) wsector <= 4'h1;
         if (half_tick && writing) begin
            o_flux <= wshift[15];
            wshift <= {wshift[14:0], 1'b0};
         end
         if (wload) begin
            wshift <= mfm_encode(wbyte, wprev) & ~wdrop;
            wprev  <= wbyte[0];
            if (crc_in) wcrc <= next_wcrc;
            if (wstate == W_DCRC && seg_end) wsector <= wsector + 1'b1;
         end
      end
   end

   // Reader: channel shift and byte decode
   read_state_t rstate;
   logic [15:0] rshift;
   logic [3:0]  rbit;
   logic        aligned;
   logic [9:0]  rcnt;
   logic [15:0] rcrc;
   logic [7:0]  id_track;
   logic [7:0]  id_head;
   logic [7:0]  id_sector;
   logic        want_data;
   logic        searching;
   logic        search_idx;
   logic [5:0]  tgt_track;
   logic        tgt_head;
   logic [3:0]  tgt_sector;
   wire  [15:0] next_rshift = {rshift[14:0], i_rd_flux};
   wire         a1_hit   = next_rshift == `FTF_A1_PATTERN;
   wire         c2_hit   = next_rshift == `FTF_C2_PATTERN;
   wire  [7:0]  rbyte    = mfm_decode(next_rshift);
   wire         rdone    = half_tick && aligned && rbit == 4'hF;
   wire         hunting  = rstate inside {P_HUNT, P_MARK, P_CMARK};
   wire  [15:0] next_rcrc = crc_byte(rcrc, rbyte);
   wire         id_match = id_track == {2'b00, tgt_track} && id_head == {7'h00, tgt_head}
                           && next_rcrc == 16'h0000;

   // Field parsing
   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         rstate  <= P_HUNT;
         rshift  <= '0;
         rbit    <= '0;
         aligned <= 1'b0;
         rcnt    <= '0;
         rcrc    <= `FTF_CRC_PRESET;
         id_track  <= '0;
         id_head   <= '0;
         id_sector <= '0;
      end else if (half_tick) begin
         rshift <= next_rshift;
         rbit   <= rbit + 1'b1;
         if (hunting && a1_hit) begin
            aligned <= 1'b1;
            rbit    <= '0;
            rcrc    <= crc_byte(rstate == P_MARK ? rcrc : `FTF_CRC_PRESET, `FTF_A1_BYTE);
            rstate  <= P_MARK;
         end else if (hunting && c2_hit) begin
            aligned <= 1'b1;
            rbit    <= '0;
            rstate  <= P_CMARK;
         end else if (rdone) begin
            rcnt <= rcnt + 1'b1;
            rcrc <= next_rcrc;
            case (rstate)
               P_MARK: begin
                  rcnt    <= '0;
                  rstate  <= (rbyte == `FTF_IDAM_BYTE) ? P_ID : (rbyte == `FTF_DAM_BYTE) ? P_DATA : P_HUNT;
                  aligned <= rbyte == `FTF_IDAM_BYTE || rbyte == `FTF_DAM_BYTE;
               end
               P_ID: begin
                  if (rcnt == 10'd0) id_track  <= rbyte;
                  if (rcnt == 10'd1) id_head   <= rbyte;
                  if (rcnt == 10'd2) id_sector <= rbyte;
                  if (rcnt == 10'd5) begin
                     rstate  <= P_HUNT;
                     aligned <= 1'b0;
                  end
               end
               P_DATA: begin
                  if (rcnt == 10'(SECTOR_BYTES + 1)) begin
                     rstate  <= P_HUNT;
                     aligned <= 1'b0;
                  end
               end
               default: begin
                  rstate  <= P_HUNT;
                  aligned <= 1'b0;
               end
            endcase
         end
      end
   end

   // Mark reports, data out, search and its revolution timeout
   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_mark_index   <= 1'b0;
         o_mark_sector  <= 1'b0;
         o_mark_data    <= 1'b0;
         o_rd_data      <= '0;
         o_rd_valid     <= 1'b0;
         o_crc_error    <= 1'b0;
         o_found        <= 1'b0;
         o_search_error <= 1'b0;
         o_bad_track    <= 1'b0;
         o_busy         <= 1'b0;
         searching      <= 1'b0;
         search_idx     <= 1'b0;
         want_data      <= 1'b0;
         tgt_track      <= '0;
         tgt_head       <= 1'b0;
         tgt_sector     <= '0;
      end else begin
         o_mark_index   <= rdone && rstate == P_CMARK && rbyte == `FTF_IAM_BYTE;
         o_mark_sector  <= rdone && rstate == P_MARK && rbyte == `FTF_IDAM_BYTE;
         o_mark_data    <= rdone && rstate == P_MARK && rbyte == `FTF_DAM_BYTE;
         o_rd_valid     <= rdone && rstate == P_DATA && want_data && rcnt < 10'(SECTOR_BYTES);
         o_rd_data      <= rbyte;
         o_crc_error    <= rdone && next_rcrc != 16'h0000
                           && ((rstate == P_ID && rcnt == 10'd5)
                               || (rstate == P_DATA && want_data && rcnt == 10'(SECTOR_BYTES + 1)));
         o_found        <= 1'b0;
         o_search_error <= 1'b0;
         o_bad_track    <= (i_format_start || i_search_start) && !track_ok;
         o_busy         <= writing || wstate == W_WAIT_INDEX || searching || want_data;
         if (rdone && rstate == P_DATA && rcnt == 10'(SECTOR_BYTES + 1)) want_data <= 1'b0;
         if (i_search_start && track_ok && !searching) begin
            searching  <= 1'b1;
            search_idx <= 1'b0;
            tgt_track  <= i_track;
            tgt_head   <= i_head;
            tgt_sector <= i_sector;
         end else if (searching && rdone && rstate == P_ID && rcnt == 10'd5 && id_match
                      && id_sector == {4'h0, tgt_sector}) begin
            searching <= 1'b0;
            o_found   <= 1'b1;
            want_data <= 1'b1;
         end else if (searching && index_edge) begin
            search_idx <= 1'b1;
            if (search_idx) begin
               searching      <= 1'b0;
               o_search_error <= 1'b1;
            end
         end
      end
   end
endmodule

/* File: framer_checker.sv */
// Port-level assertions for the track framer
`timescale 1ns/100ps
module framer_checker #(
   parameter int HALF = 50
) (
   // Clock, reset and drive
   input wire logic       i_clock,
   input wire logic       i_arst_n,
   input wire logic       i_index,
   input wire logic       o_flux,
   input wire logic       o_write_gate,
   input wire logic       o_drive_ready,
   // Commands and status
   input wire logic       i_format_start,
   input wire logic [5:0] i_track,
   input wire logic       o_busy,
   input wire logic       o_bad_track,
   input wire logic       o_found,
   input wire logic       o_search_error,
   input wire logic       o_rd_valid
);
   logic [6:0] since;
   logic       last;
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_arst_n);
   // Cycles since the channel bit last moved, saturating so it never wraps
   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         since <= 7'h7F;
         last  <= 1'b0;
      end else begin
         last  <= o_flux;
         since <= (o_flux != last) ? 7'h00 : ((since == 7'h7F) ? since : since + 7'h01);
      end
   end
   chk_bad_track: assert property (i_format_start && !o_busy && i_track >= 6'h28
      |=> o_bad_track && !o_busy) else $error("bad track accepted");
   chk_format_busy: assert property (i_format_start && !o_busy && i_track < 6'h28
      |-> ##2 o_busy) else $error("format not taken");
   chk_gate_start: assert property ($rose(o_write_gate) |-> o_busy && $past(i_index))
      else $error("gate rose away from index");
   chk_gate_end: assert property ($fell(o_write_gate) |-> $past(i_index))
      else $error("gate fell away from index");
   chk_ready_hold: assert property (o_drive_ready |=> o_drive_ready)
      else $error("drive ready dropped");
   chk_ready_index: assert property ($rose(o_drive_ready) |-> $past(i_index))
      else $error("ready without index");
   chk_error_index: assert property ($rose(o_search_error) |-> $past(i_index))
      else $error("search error away from index");
   chk_found_pulse: assert property (o_found |=> !o_found && !o_search_error)
      else $error("found pulse too long");
   chk_byte_gap: assert property (o_rd_valid |=> !o_rd_valid [*8])
      else $error("read bytes too close");
   chk_half_cell: assert property (o_write_gate && o_flux != last |-> since >= 7'(HALF - 1))
      else $error("channel bit faster than half cell");
endmodule

bind floppy_track_format_framer framer_checker #(.HALF(HALF)) u_chk (
   .i_clock, .i_arst_n, .i_index, .o_flux, .o_write_gate, .o_drive_ready, .i_format_start,
   .i_track, .o_busy, .o_bad_track, .o_found, .o_search_error, .o_rd_valid
);

/* File: drive_model.sv */
// Drive model: index hole and media that reads back what is written
`timescale 1ns/100ps
module drive_model #(
   parameter int PERIOD = 32000,
   parameter int FIRST  = 100
) (
   input  wire logic i_clock,
   input  wire logic i_flux,
   input  wire logic i_write_gate,
   output logic      o_index = 1'b0,
   output logic      o_rd_flux
);
   int   cnt = 0;
   logic junk = 1'b0;
   // Index pulse once a turn, 100 cycles wide
   always @(negedge i_clock) begin
      cnt     <= cnt + 1;
      o_index <= (cnt >= FIRST) && ((cnt - FIRST) % PERIOD < 100);
      junk    <= !junk;
   end
   // Unwritten media gives a changing pattern, not the last bit
   assign o_rd_flux = i_write_gate ? i_flux : junk;
endmodule

/* File: floppy_track_format_framer_tb.sv */
// Self-checking bench for the track framer
`timescale 1ns/100ps
module floppy_track_format_framer_tb;
   logic       i_clock = 1'b0, i_arst_n = 1'b0, i_format_start = 1'b0, i_search_start = 1'b0;
   logic [5:0] i_track = 6'h00;
   logic       i_head = 1'b0, i_wr_valid = 1'b0;
   logic [3:0] i_sector = 4'h1;
   logic [7:0] i_wr_data = 8'h00;
   logic       i_index, i_rd_flux, o_flux, o_write_gate, o_drive_ready, o_busy, o_bad_track, o_found;
   logic       o_search_error, o_crc_error, o_wr_ready, o_underrun, o_rd_valid;
   logic       o_mark_index, o_mark_sector, o_mark_data, idx_prev = 1'b0;
   logic [7:0] o_rd_data, wbytes [3] = '{8'h3C, 8'hFF, 8'h01}, rd_q [$];
   logic [6:0] ev;
   int         n [7], n_idx = 0, failures = 0, cmp_count = 0;

   // One short sector and fast bit cells, so three revolutions fit the run
   floppy_track_format_framer #(.SECTORS(1), .SECTOR_BYTES(3), .HALF_CYCLES(2)) u_dut (.i_clock,
      .i_arst_n, .i_index, .i_rd_flux, .o_flux,
      .o_write_gate, .o_drive_ready, .i_format_start, .i_search_start, .i_track, .i_head, .i_sector,
      .o_busy, .o_bad_track, .o_found, .o_search_error, .o_crc_error, .i_wr_data, .i_wr_valid,
      .o_wr_ready, .o_underrun, .o_mark_index, .o_mark_sector, .o_mark_data, .o_rd_data, .o_rd_valid);
   drive_model #(.PERIOD(8000)) u_drive (.i_clock, .i_flux(o_flux), .i_write_gate(o_write_gate),
      .o_index(i_index), .o_rd_flux(i_rd_flux));

   assign ev = {o_underrun, o_found, o_search_error, o_crc_error, o_mark_index, o_mark_sector, o_mark_data};
   initial forever #10 i_clock = ~i_clock;
   // Count event pulses and index edges, collect parsed bytes
   always @(negedge i_clock) begin
      idx_prev <= i_index;
      if (i_index === 1'b1 && idx_prev === 1'b0) n_idx++;
      foreach (n[k]) if (ev[k] === 1'b1) n[k]++;
      if (o_rd_valid === 1'b1) rd_q.push_back(o_rd_data);
   end

   task automatic check(input logic ok, input string msg);
      cmp_count++;
      if (ok !== 1'b1) begin
         failures++;
         $display("MISMATCH at %0t: %s", $time, msg);
      end
   endtask

   task automatic end_sim;
      if (failures == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   // Track 40 is refused before any index
   task automatic bad_track_test;
      i_track = 6'h28;
      i_format_start = 1'b1;
      @(negedge i_clock);
      i_format_start = 1'b0;
      check(o_bad_track === 1'b1 && o_busy === 1'b0, "bad track");
      check(o_drive_ready === 1'b0, "ready early");
   endtask

   // Format track 39 while a search reads it back; buffer fills and stalls
   task automatic format_test;
      logic rdy;
      int   w;
      i_track = 6'h27;
      i_head = 1'b1;
      i_format_start = 1'b1;
      @(negedge i_clock);
      i_format_start = 1'b0;
      i_search_start = 1'b1;
      @(negedge i_clock);
      i_search_start = 1'b0;
      check(o_busy === 1'b1, "not busy");
      foreach (wbytes[i]) begin
         i_wr_data = wbytes[i];
         i_wr_valid = 1'b1;
         w = 0;
         do begin
            rdy = o_wr_ready;
            w++;
            @(negedge i_clock);
         end while (rdy !== 1'b1);
      end
      i_wr_valid = 1'b0;
      check(w > 1000, "full buffer took a byte");
      check(o_drive_ready === 1'b0, "ready early");
      wait (o_write_gate === 1'b0);
      repeat (2) @(negedge i_clock);
      check(n[5] == 1 && n[4] == 0, "sector not found");
      check(n[2] == 1, "index mark");
      check(n[1] == 1, "id mark");
      check(n[0] == 1, "data mark");
      check(n[3] == 0 && n[6] == 0, "crc or underrun");
      check(rd_q.size() == 3, "byte count");
      foreach (wbytes[i]) check(rd_q[i] === wbytes[i], "data byte");
      check(o_drive_ready === 1'b1, "not ready");
   endtask

   // Absent sector: give up at the second index edge
   task automatic miss_test;
      int i0;
      i_sector = 4'h5;
      i_search_start = 1'b1;
      i0 = n_idx;
      @(negedge i_clock);
      i_search_start = 1'b0;
      wait (n[4] == 1);
      check(n_idx - i0 == 2 && n[5] == 1, "timeout");
   endtask

   initial begin
      repeat (4) @(negedge i_clock);
      i_arst_n = 1'b1;
      bad_track_test();
      format_test();
      miss_test();
      end_sim();
   end

   // Watchdog: three revolutions plus margin
   initial begin
      repeat (40000) @(posedge i_clock);
      failures++;
      end_sim();
   end
endmodule
